//--- mmx_exec.sv
// Purpose: decode and execute of move, literal load and literal multiply
// Assumes: i_insn valid while i_q1 pulses; memory read data is combinational
// Notes:   o_mem_* are registered one clock after the quarter that asks
// Summary of operation
// (RQ1) move is word 1100+source address then word 1111+dest address.
// (RQ2) move addresses span all 4096 bytes and ignore the bank register.
// (RQ3) move may use the working register at either end, no flags change.
// (RQ4) software never names counter low or stack top as move destination.
// (RQ5) move takes two words and two cycles, three when stretched.
// (RQ6) 0000 0001 plus literal loads the bank register, no flags change.
// (RQ7) 0000 1110 plus literal loads the working register, no flags.
// (RQ8) 0110 111a plus address stores the working register to memory.
// (RQ9) access bit 0 picks the access bank, 1 picks the bank register.
// (RQ10) the 8-bit store address reaches all 256 bytes of its bank.
// (RQ11) 0000 1101 plus literal puts working times literal in product pair.
// (RQ12) literal multiply keeps the working register and sets no flags.
// (RQ13) move reads source in q2 of cycle one, writes dest in q4 of two.
// (RQ14) single-word ops decode q1, read q2, process q3, write q4.
`timescale 1ns/100ps
module mmx_exec (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_insn,
    input  wire logic        i_q1,
    input  wire logic        i_q2,
    input  wire logic        i_q3,
    input  wire logic        i_q4,
    input  wire logic        i_stretch,
    input  wire logic [7:0]  i_mem_rdata,
    output logic      [11:0] o_mem_addr,
    output logic             o_mem_rd,
    output logic             o_mem_wr,
    output logic      [7:0]  o_mem_wdata,
    output logic      [7:0]  o_working_register,
    output logic      [7:0]  o_bank_select_register,
    output logic      [7:0]  o_product_high_byte,
    output logic      [7:0]  o_product_low_byte,
    output logic             o_busy
);
    mmx_mem_if mem ();

    mmx_pkg::mmx_op_t op;
    mmx_pkg::mmx_op_t next_op;
    logic [7:0]  lit;
    logic [7:0]  next_lit;
    logic [7:0]  hold;
    logic [7:0]  next_hold;
    logic [11:0] dst;
    logic [11:0] next_dst;
    logic        wait_cyc;
    logic        next_wait_cyc;
    logic [7:0]  working_register;
    logic [7:0]  next_working_register;
    logic [7:0]  bank_select_register;
    logic [7:0]  next_bsr;
    logic [15:0] prod;
    logic [15:0] next_prod;
    logic [15:0] mul_res;
    logic        mem_phase;
    logic        next_mem_phase;

    assign mul_res = 16'(working_register) * 16'(lit); // RQ11

    always_comb begin
        next_op       = op;
        next_lit      = lit;
        next_hold     = hold;
        next_dst      = dst;
        next_wait_cyc = wait_cyc;
        next_working_register     = working_register;
        next_bsr      = bank_select_register;
        next_prod     = prod;
        mem.addr      = 12'h000;
        mem.rd        = 1'b0;
        mem.wr        = 1'b0;
        mem.wdata     = 8'h00;
        if (i_q1) begin
            if (op == mmx_pkg::MMX_MOVE_DST) begin
                // second word supplies the destination
                if (i_insn[15:12] == mmx_pkg::PFX_MOVE_DST) // RQ1
                    next_dst = i_insn[11:0]; // RQ2
                else
                    next_op = mmx_pkg::MMX_IDLE;
            end else begin
                next_lit = i_insn[7:0];
                next_wait_cyc = i_stretch; // RQ5
                if (i_insn[15:12] == mmx_pkg::PFX_MOVE_SRC) begin // RQ1
                    next_op  = mmx_pkg::MMX_MOVE_DST;
                    next_dst = i_insn[11:0];
                end else if (i_insn[15:8] == mmx_pkg::OP_BANK_LIT)
                    next_op = mmx_pkg::MMX_BANK; // RQ6
                else if (i_insn[15:8] == mmx_pkg::OP_WORK_LIT)
                    next_op = mmx_pkg::MMX_WORK; // RQ7
                else if (i_insn[15:8] == mmx_pkg::OP_MUL_LIT)
                    next_op = mmx_pkg::MMX_MUL; // RQ11
                else if (i_insn[15:9] == mmx_pkg::OP_WORK_ST) begin
                    next_op = mmx_pkg::MMX_STORE; // RQ8
                    next_dst = i_insn[8] ? {bank_select_register[3:0], i_insn[7:0]} // RQ9 RQ10
                        : {mmx_pkg::ACCESS_BANK, i_insn[7:0]};
                end else
                    next_op = mmx_pkg::MMX_IDLE;
            end
        end
        // source read of the move: first cycle, second quarter
        if (i_q2 && op == mmx_pkg::MMX_MOVE_DST && !mem_phase) begin
            mem.addr = dst; // RQ13
            mem.rd = 1'b1;
        end
        // the read strobe reaches the pins one clock later, so the
        // answer is taken in q3 while the source address stands there
        if (i_q3 && op == mmx_pkg::MMX_MOVE_DST && !mem_phase)
            next_hold = (dst == mmx_pkg::WORK_ADDR) ? working_register
                : i_mem_rdata; // RQ3 RQ13
        if (i_q4) begin
            case (op)
                mmx_pkg::MMX_BANK: next_bsr = lit; // RQ6 RQ14
                mmx_pkg::MMX_WORK: next_working_register = lit; // RQ7 RQ14
                mmx_pkg::MMX_MUL:  next_prod = mul_res; // RQ11 RQ12
                mmx_pkg::MMX_STORE: begin
                    mem.addr = dst; // RQ8
                    mem.wr = 1'b1;
                    mem.wdata = working_register;
                    if (dst == mmx_pkg::WORK_ADDR)
                        next_working_register = working_register; // RQ3
                end
                mmx_pkg::MMX_MOVE_DST: begin
                    if (mem_phase && wait_cyc)
                        next_wait_cyc = 1'b0; // RQ5
                    else if (mem_phase) begin
                        mem.addr = dst; // RQ13
                        mem.wr = 1'b1;
                        mem.wdata = hold;
                        if (dst == mmx_pkg::WORK_ADDR)
                            next_working_register = hold; // RQ3
                    end
                end
                default: begin
                end
            endcase
            if (op != mmx_pkg::MMX_MOVE_DST || (mem_phase && !wait_cyc))
                next_op = mmx_pkg::MMX_IDLE;
        end
    end

    // move phase: 0 during the first word's cycle, 1 afterwards
    always_comb begin
        next_mem_phase = mem_phase;
        if (i_q4 && op == mmx_pkg::MMX_MOVE_DST)
            next_mem_phase = 1'b1;
        if (i_q4 && (op != mmx_pkg::MMX_MOVE_DST
                     || (mem_phase && !wait_cyc)))
            next_mem_phase = 1'b0;
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            op        <= mmx_pkg::MMX_IDLE;
            lit       <= mmx_pkg::RST_BYTE;
            hold      <= mmx_pkg::RST_BYTE;
            dst       <= 12'h000;
            wait_cyc  <= 1'b0;
            working_register      <= mmx_pkg::RST_BYTE;
            bank_select_register       <= mmx_pkg::RST_BYTE;
            prod      <= 16'h0000;
            mem_phase <= 1'b0;
        end else begin
            op        <= next_op;
            lit       <= next_lit;
            hold      <= next_hold;
            dst       <= next_dst;
            wait_cyc  <= next_wait_cyc;
            working_register      <= next_working_register;
            bank_select_register       <= next_bsr;
            prod      <= next_prod;
            mem_phase <= next_mem_phase;
        end
    end

    assign o_working_register     = working_register;
    assign o_bank_select_register = bank_select_register;
    assign o_product_high_byte    = prod[15:8];
    assign o_product_low_byte     = prod[7:0];
    assign o_busy                 = (op == mmx_pkg::MMX_MOVE_DST);

    mmx_mem_port u_port (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .mem       (mem.mem),
        .i_rdata   (i_mem_rdata),
        .o_addr    (o_mem_addr),
        .o_rd      (o_mem_rd),
        .o_wr      (o_mem_wr),
        .o_wdata   (o_mem_wdata)
    );

    a_mul_product: assert property (@(posedge i_clk_sys) // RQ11
        disable iff (i_sys_rst)
        (i_q4 && op == mmx_pkg::MMX_MUL) |=> prod == $past(mul_res))
        else $error("product pair wrong after literal multiply");
    a_mul_keeps_w: assert property (@(posedge i_clk_sys) // RQ12
        disable iff (i_sys_rst)
        (i_q4 && op == mmx_pkg::MMX_MUL) |=> $stable(working_register))
        else $error("literal multiply changed working register");
    a_bank_load: assert property (@(posedge i_clk_sys) // RQ6
        disable iff (i_sys_rst)
        (i_q4 && op == mmx_pkg::MMX_BANK) |=> bank_select_register == $past(lit))
        else $error("bank register not loaded");
    a_work_load: assert property (@(posedge i_clk_sys) // RQ7
        disable iff (i_sys_rst)
        (i_q4 && op == mmx_pkg::MMX_WORK) |=> working_register == $past(lit))
        else $error("working register not loaded");
    a_store_write: assert property (@(posedge i_clk_sys) // RQ8
        disable iff (i_sys_rst)
        (i_q4 && op == mmx_pkg::MMX_STORE) |=> o_mem_wr
            && o_mem_wdata == $past(working_register))
        else $error("store did not write working register");
    a_store_access: assert property (@(posedge i_clk_sys) // RQ9
        disable iff (i_sys_rst)
        (i_q1 && op != mmx_pkg::MMX_MOVE_DST
         && i_insn[15:9] == mmx_pkg::OP_WORK_ST && !i_insn[8])
        |=> dst[11:8] == mmx_pkg::ACCESS_BANK)
        else $error("access bank not selected");
    a_move_rd_q2: assert property (@(posedge i_clk_sys) // RQ13
        disable iff (i_sys_rst)
        mem.rd |-> i_q2 && !mem_phase)
        else $error("move read outside first cycle q2");
    a_move_wr_q4: assert property (@(posedge i_clk_sys) // RQ13
        disable iff (i_sys_rst)
        mem.wr |-> i_q4)
        else $error("write outside q4");

    sequence s_move_commit;
        i_q4 && op == mmx_pkg::MMX_MOVE_DST && mem_phase && !wait_cyc;
    endsequence
    sequence s_move_strobe;
        o_mem_wr && o_mem_wdata == $past(hold) && o_mem_addr == $past(dst);
    endsequence
    a_move_write: assert property (@(posedge i_clk_sys) // RQ13
        disable iff (i_sys_rst)
        s_move_commit |=> s_move_strobe)
        else $error("move did not write held source byte");
endmodule

//--- mmx_mem_if.sv
// Purpose: data memory port between executor and its memory access unit
// Assumes: single-cycle read data
// Notes:   none
`timescale 1ns/100ps
interface mmx_mem_if;
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport exec (output addr, output rd, output wr, output wdata,
                  input rdata);
    modport mem  (input addr, input rd, input wr, input wdata,
                  output rdata);
endinterface

//--- mmx_mem_port.sv
// Purpose: registers data memory strobes onto the top-level pins
// Assumes: read data returns from the memory on the same clock
// Notes:   strobes are delayed by one clock edge
`timescale 1ns/100ps
module mmx_mem_port (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    mmx_mem_if.mem           mem,
    input  wire logic [7:0]  i_rdata,
    output logic      [11:0] o_addr,
    output logic             o_rd,
    output logic             o_wr,
    output logic      [7:0]  o_wdata
);
    assign mem.rdata = i_rdata;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_addr  <= 12'h000;
            o_rd    <= 1'b0;
            o_wr    <= 1'b0;
            o_wdata <= 8'h00;
        end else begin
            o_addr  <= mem.addr;
            o_rd    <= mem.rd;
            o_wr    <= mem.wr;
            o_wdata <= mem.wdata;
        end
    end
endmodule

//--- mmx_pkg.sv
// Purpose: constants and types for the move/multiply instruction executor
// Assumes: 16-bit instruction words, 12-bit data addresses, 8-bit data
// Notes:   quarter phases q1..q4 form one instruction cycle
package mmx_pkg;
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned INSN_W       = 16;
    localparam logic [3:0]  PFX_MOVE_SRC = 4'hc;
    localparam logic [3:0]  PFX_MOVE_DST = 4'hf;
    localparam logic [7:0]  OP_BANK_LIT  = 8'h01;
    localparam logic [7:0]  OP_WORK_LIT  = 8'h0e;
    localparam logic [7:0]  OP_MUL_LIT   = 8'h0d;
    localparam logic [6:0]  OP_WORK_ST   = 7'h37;
    localparam logic [3:0]  ACCESS_BANK  = 4'h0;
    localparam logic [ADDR_W-1:0] WORK_ADDR = 12'hfe8;
    localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
    localparam logic [1:0]  Q_RST        = 2'h0;
    typedef enum logic [2:0] {
        MMX_IDLE, MMX_MOVE_DST, MMX_BANK, MMX_WORK, MMX_STORE, MMX_MUL
    } mmx_op_t;
endpackage

//--- testbench.sv
// Purpose: self-checking bench for the move/multiply instruction executor
// Assumes: quarter pulses one clock each, results settled three clocks after q4
// Notes:   a small memory array answers reads and records every write strobe
`timescale 1ns/100ps
module testbench;
    logic        i_clk_sys = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [15:0] i_insn    = 16'h0000;
    logic        i_q1 = 1'b0, i_q2 = 1'b0, i_q3 = 1'b0, i_q4 = 1'b0;
    logic        i_stretch = 1'b0;
    logic [7:0]  i_mem_rdata;
    logic [11:0] o_mem_addr;
    logic        o_mem_rd, o_mem_wr, o_busy;
    logic [7:0]  o_mem_wdata, o_working_register, o_bank_select_register;
    logic [7:0]  o_product_high_byte, o_product_low_byte;
    int          error_cnt = 0, checks_done = 0, wr_n = 0, rd_n = 0;
    logic [11:0] wr_a, rd_a;
    logic [7:0]  wr_d;
    logic [7:0]  mem [4096];

    mmx_exec mmx_exec_inst (.i_clk_sys, .i_sys_rst, .i_insn, .i_q1, .i_q2,
        .i_q3, .i_q4, .i_stretch, .i_mem_rdata, .o_mem_addr, .o_mem_rd,
        .o_mem_wr, .o_mem_wdata, .o_working_register,
        .o_bank_select_register, .o_product_high_byte, .o_product_low_byte,
        .o_busy);

    always #25 i_clk_sys = ~i_clk_sys;
    assign i_mem_rdata = mem[o_mem_addr];

    // memory side: record strobes as the executor issues them
    always @(posedge i_clk_sys) begin
        if (o_mem_wr === 1'b1) begin
            mem[o_mem_addr] <= o_mem_wdata;
            wr_a = o_mem_addr;
            wr_d = o_mem_wdata;
            wr_n++;
        end
        if (o_mem_rd === 1'b1) begin
            rd_a = o_mem_addr;
            rd_n++;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one instruction cycle; entered and left on a rising edge
    task automatic cyc(input logic [15:0] w);
        i_insn <= w;
        i_q1   <= 1'b1;
        @(posedge i_clk_sys);
        i_q1 <= 1'b0;
        i_q2 <= 1'b1;
        @(posedge i_clk_sys);
        i_q2 <= 1'b0;
        i_q3 <= 1'b1;
        @(posedge i_clk_sys);
        i_q3 <= 1'b0;
        i_q4 <= 1'b1;
        @(posedge i_clk_sys);
        i_q4 <= 1'b0;
    endtask

    task automatic settle;
        repeat (3) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic fin(input string n);
        $display("test %s finished, errors so far %0d", n, error_cnt);
    endtask

    task automatic t_reset;
        @(posedge i_clk_sys);
        #1;
        chk(o_working_register, 16'h0000);
        chk(o_bank_select_register, 16'h0000);
        chk({o_product_high_byte, o_product_low_byte}, 16'h0000);
        chk(o_busy, 16'h0000);
        fin("reset");
    endtask

    task automatic t_lits;
        @(posedge i_clk_sys);
        cyc(16'h0e5a);
        cyc(16'h0105);
        settle;
        chk(o_working_register, 16'h005a);
        chk(o_bank_select_register, 16'h0005);
        fin("literal loads");
    endtask

    task automatic t_mul;
        logic [7:0] wv [4] = '{8'he2, 8'h00, 8'hff, 8'h01};
        logic [7:0] kv [4] = '{8'hc4, 8'hab, 8'hff, 8'h00};
        @(posedge i_clk_sys);
        for (int i = 0; i < 4; i++) begin
            cyc({8'h0e, wv[i]});
            cyc({8'h0d, kv[i]});
            settle;
            chk({o_product_high_byte, o_product_low_byte},
                16'(wv[i]) * 16'(kv[i]));
            chk(o_working_register, wv[i]);
            @(posedge i_clk_sys);
        end
        fin("literal multiply");
    endtask

    task automatic t_store;
        int n0;
        @(posedge i_clk_sys);
        cyc(16'h0e4f);
        cyc(16'h0105);
        n0 = wr_n;
        cyc(16'h6eff);
        settle;
        chk({wr_a, 4'h0}, 16'h0ff0);
        chk(wr_d, 16'h004f);
        @(posedge i_clk_sys);
        cyc(16'h6f00);
        settle;
        chk({wr_a, 4'h0}, 16'h5000);
        chk(16'(wr_n - n0), 16'h0002);
        fin("working store");
    endtask

    // destinations avoid counter low and stack top bytes
    task automatic t_move(input logic [11:0] s, input logic [11:0] d,
                          input logic st);
        int         n0;
        int         r0;
        logic [7:0] ev;
        @(posedge i_clk_sys);
        ev = (s == mmx_pkg::WORK_ADDR) ? o_working_register : mem[s];
        n0 = wr_n;
        r0 = rd_n;
        i_stretch <= st;
        cyc({mmx_pkg::PFX_MOVE_SRC, s});
        i_stretch <= 1'b0;
        #1;
        chk(o_busy, 16'h0001);
        if (st) begin
            cyc({mmx_pkg::PFX_MOVE_DST, d});
        end
        cyc({mmx_pkg::PFX_MOVE_DST, d});
        settle;
        if (d == mmx_pkg::WORK_ADDR) begin
            chk(o_working_register, ev);
        end else begin
            chk({wr_a, 4'h0}, {d, 4'h0});
            chk(wr_d, ev);
            chk(16'(wr_n - n0), 16'h0001);
        end
        if (s != mmx_pkg::WORK_ADDR) begin
            chk({rd_a, 4'h0}, {s, 4'h0});
        end
        chk(16'(rd_n - r0), 16'h0001);
        chk(o_busy, 16'h0000);
        fin("file move");
    endtask

    task automatic t_abort;
        int n0;
        @(posedge i_clk_sys);
        n0 = wr_n;
        cyc(16'hc123);
        cyc(16'h0000);
        settle;
        chk(16'(wr_n - n0), 16'h0000);
        chk(o_busy, 16'h0000);
        fin("move abort");
    endtask

    task automatic give_verdict;
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        error_cnt++;
        give_verdict;
    end

    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ 8'h3c;
        end
        repeat (12) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        t_reset;
        t_lits;
        t_mul;
        t_store;
        t_move(12'hfff, 12'h123, 1'b0);
        t_move(12'h000, 12'h7a0, 1'b1);
        t_move(12'hfe8, 12'h000, 1'b0);
        t_move(12'hffe, 12'hfe8, 1'b0);
        t_abort;
        give_verdict;
    end
endmodule
